// ---- hdl/fgc_pkg.sv ----
// Purpose: Shared constants of the fuel gauge standard command map.
// Assumes: 7-bit command codes, 16-bit command words, 20 MHz mclk.
// Notes:   Codes are even; the odd partner of a pair holds the high byte.
package fgc_pkg;
  localparam int unsigned MCLK_MHZ      = 20;
  localparam int unsigned SOC_PULSE_US  = 1000;
  localparam int unsigned SOC_PULSE_CYC = SOC_PULSE_US * MCLK_MHZ;
  localparam int unsigned WORD_CNT      = 64;
  localparam int unsigned MFG_BYTES     = 32;

  localparam logic [6:0] CMD_CTL      = 7'h00;
  localparam logic [6:0] CMD_RATE     = 7'h02;
  localparam logic [6:0] CMD_RATE_TTE = 7'h04;
  localparam logic [6:0] CMD_TEMP     = 7'h06;
  localparam logic [6:0] CMD_VOLT     = 7'h08;
  localparam logic [6:0] CMD_FLAGS    = 7'h0a;
  localparam logic [6:0] CMD_NOM_AV   = 7'h0c;
  localparam logic [6:0] CMD_FULL_AV  = 7'h0e;
  localparam logic [6:0] CMD_LEFT     = 7'h10;
  localparam logic [6:0] CMD_FULL     = 7'h12;
  localparam logic [6:0] CMD_EFF_I    = 7'h14;
  localparam logic [6:0] CMD_RT_LEFT  = 7'h16;
  localparam logic [6:0] CMD_CT_LEFT  = 7'h18;
  localparam logic [6:0] CMD_IDLE_I   = 7'h1a;
  localparam logic [6:0] CMD_IDLE_RT  = 7'h1c;
  localparam logic [6:0] CMD_PEAK_I   = 7'h1e;
  localparam logic [6:0] CMD_PEAK_RT  = 7'h20;
  localparam logic [6:0] CMD_ENERGY   = 7'h22;
  localparam logic [6:0] CMD_POWER    = 7'h24;
  localparam logic [6:0] CMD_CP_RT    = 7'h26;
  localparam logic [6:0] CMD_WEAR     = 7'h28;
  localparam logic [6:0] CMD_CYCLES   = 7'h2a;
  localparam logic [6:0] CMD_SOC      = 7'h2c;
  localparam logic [6:0] CMD_DIE      = 7'h36;
  localparam logic [6:0] CMD_OPTS     = 7'h3a;
  localparam logic [6:0] CMD_DF_SEL   = 7'h3e;
  localparam logic [6:0] CMD_APP      = 7'h6a;
  localparam logic [1:0] MFG_WINDOW   = 2'b10;

  localparam logic [15:0] SUB_STATUS    = 16'h0000;
  localparam logic [15:0] SUB_SET_HIB   = 16'h0011;
  localparam logic [15:0] SUB_CLEAR_HIB = 16'h0012;
  localparam logic [15:0] SUB_LOCK      = 16'h0020;
  localparam int unsigned ST_LOCKED_BIT = 13;
  localparam int unsigned ST_HIB_BIT    = 6;
  localparam int unsigned ST_SLEEP_BIT  = 4;
  localparam int unsigned OPT_TEMP_EXT_BIT = 0;
  localparam logic [15:0] RESET_WORD    = 16'h0000;

  typedef enum logic [1:0] {
    FGC_NORMAL = 2'b00, FGC_SLEEP = 2'b01, FGC_HIBERNATE = 2'b11, FGC_PACK_CHECK = 2'b10
  } fgc_mode_t;

  typedef enum logic [2:0] {
    FGC_IDLE = 3'b000, FGC_ADDR = 3'b001, FGC_ACK_A = 3'b011, FGC_WR = 3'b010,
    FGC_ACK_W = 3'b110, FGC_RD = 3'b111, FGC_ACK_R = 3'b101
  } fgc_link_t;
endpackage

// ---- hdl/fgc_cmd_map.sv ----
// Purpose: Standard command map of a fuel gauge behind a two-wire target port.
// Assumes: Gauging engine on mclk feeds measured words through the update port.
// Notes:   The target never stretches the serial clock; reads and writes auto-increment.
`timescale 1ns/100ps

// What this block does
// - Each battery value is a 16-bit word reached by a pair of consecutive command codes.
// - Every other transfer type works at serial clock rates up to 400 kHz.
// - Read and write permission of each command follows the locked or unlocked state.
// - Both command sets reach the control and status words and the data-flash space.
// - A 32-byte user manufacturer area is reachable only through the data-flash window.
// - Normal, sleep, hibernate and pack check modes change on events or host request.
// - A charge-level interrupt pin pulses when the engine changes the charge percentage word.
// - Battery temperature comes from the thermistor or the on-chip sensor by configuration.
// - The control word sits at codes 0x00 and 0x01 and is read-write while locked.
// - Temperature sits at codes 0x06 and 0x07 in 0.1 K and accepts writes while locked.
// - Charge percentage at 0x2c is read-only when locked; the rate setpoint at 0x02 is R/W.
module fgc_cmd_map #(
  parameter logic [6:0]  DEV_ADDR     = 7'h2a,
  parameter logic [7:0]  MFG_SUBCLASS = 8'h01,
  parameter int unsigned SOC_PULSE    = fgc_pkg::SOC_PULSE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             soc_int_out,
  output logic             soc_int_oe,
  input  wire logic        gauge_wr_en,
  input  wire logic [6:0]  gauge_wr_code,
  input  wire logic [15:0] gauge_wr_data,
  input  wire logic        temp_sample_valid,
  input  wire logic [15:0] ext_temp_dk,
  input  wire logic [15:0] die_temp_dk,
  input  wire logic [15:0] ctl_reply,
  input  wire logic        unlock_grant,
  input  wire logic        sleep_cond,
  input  wire logic        wake_event,
  input  wire logic        pack_absent,
  output logic             locked_access_state,
  output logic [1:0]       power_mode,
  output logic             temp_src_ext,
  output logic [15:0]      rate_setpoint_ma,
  output logic             ctl_sub_valid,
  output logic [15:0]      ctl_sub_code
);

  localparam logic [5:0] IDX_TEMP = fgc_pkg::CMD_TEMP[6:1];
  localparam logic [5:0] IDX_DIE  = fgc_pkg::CMD_DIE[6:1];
  localparam logic [5:0] IDX_SOC  = fgc_pkg::CMD_SOC[6:1];
  localparam logic [5:0] IDX_RATE = fgc_pkg::CMD_RATE[6:1];
  localparam logic [5:0] IDX_OPTS = fgc_pkg::CMD_OPTS[6:1];
  localparam logic [5:0] IDX_DF   = fgc_pkg::CMD_DF_SEL[6:1];
  localparam logic [31:0] SOC_LAST = SOC_PULSE - 1;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic is_mapped(input logic [6:0] c);
    logic [6:0] even;
    even = {c[6:1], 1'b0};
    case (even)
      fgc_pkg::CMD_CTL, fgc_pkg::CMD_RATE, fgc_pkg::CMD_RATE_TTE, fgc_pkg::CMD_TEMP,
      fgc_pkg::CMD_VOLT, fgc_pkg::CMD_FLAGS, fgc_pkg::CMD_NOM_AV, fgc_pkg::CMD_FULL_AV,
      fgc_pkg::CMD_LEFT, fgc_pkg::CMD_FULL, fgc_pkg::CMD_EFF_I, fgc_pkg::CMD_RT_LEFT,
      fgc_pkg::CMD_CT_LEFT, fgc_pkg::CMD_IDLE_I, fgc_pkg::CMD_IDLE_RT, fgc_pkg::CMD_PEAK_I,
      fgc_pkg::CMD_PEAK_RT, fgc_pkg::CMD_ENERGY, fgc_pkg::CMD_POWER, fgc_pkg::CMD_CP_RT,
      fgc_pkg::CMD_WEAR, fgc_pkg::CMD_CYCLES, fgc_pkg::CMD_SOC, fgc_pkg::CMD_DIE,
      fgc_pkg::CMD_OPTS, fgc_pkg::CMD_DF_SEL, fgc_pkg::CMD_APP: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic rw_when_locked(input logic [6:0] c);
    rw_when_locked = (c[6:1] == IDX_RATE) || (c[6:1] == IDX_TEMP) || (c[6:1] == IDX_DF);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Both pins are asynchronous to mclk; the edge logic compares the second stage with the third.
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_s1, scl_s2, scl_d} <= 3'b111;
      {sda_s1, sda_s2, sda_d} <= 3'b111;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
    end
  end

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

  ////////////////////////////////////////////////////////////////////////////////
  fgc_pkg::fgc_link_t link;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [6:0]  ptr;
  logic        rnw, code_phase, host_nack, drive_low;
  logic        bw_en;
  logic [6:0]  bw_code;
  logic [7:0]  bw_data;
  logic [15:0] regs [0:fgc_pkg::WORD_CNT-1];
  logic [7:0]  mfg  [0:fgc_pkg::MFG_BYTES-1];
  logic [15:0] ctl_resp;
  logic [7:0]  rd_byte;

  wire [15:0] rd_word = (ptr[6:1] == 6'h00) ? ctl_resp :
                        (is_mapped(ptr) ? regs[ptr[6:1]] : fgc_pkg::RESET_WORD);
  wire df_hit = (regs[IDX_DF][7:0] == MFG_SUBCLASS) && (regs[IDX_DF][15:8] == 8'h00);
  assign rd_byte = (ptr[6:5] == fgc_pkg::MFG_WINDOW) ? (df_hit ? mfg[ptr[4:0]] : 8'h00) :
                   (ptr[0] ? rd_word[15:8] : rd_word[7:0]);

  // Sampling at mclk gives over 20 samples per serial clock phase at 400 kHz.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      link <= fgc_pkg::FGC_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 7'h00;
      {rnw, code_phase, host_nack, drive_low, bw_en} <= 5'b00000;
      bw_code <= 7'h00;
      bw_data <= 8'h00;
    end else begin
      bw_en <= 1'b0;
      if (bus_start) begin
        link <= fgc_pkg::FGC_ADDR;
        bitcnt <= 4'h0;
        drive_low <= 1'b0;
      end else if (bus_stop) begin
        link <= fgc_pkg::FGC_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (link)
          fgc_pkg::FGC_ADDR, fgc_pkg::FGC_WR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s2};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              drive_low <= 1'b1;
              if (link == fgc_pkg::FGC_ADDR) begin
                rnw <= shreg[0];
                link <= (shreg[7:1] == DEV_ADDR) ? fgc_pkg::FGC_ACK_A : fgc_pkg::FGC_IDLE;
                drive_low <= (shreg[7:1] == DEV_ADDR);
              end else begin
                link <= fgc_pkg::FGC_ACK_W;
                if (code_phase) begin
                  ptr <= shreg[6:0];
                  code_phase <= 1'b0;
                end else begin
                  bw_en <= 1'b1;
                  bw_code <= ptr;
                  bw_data <= shreg;
                  ptr <= ptr + 7'h01;
                end
              end
            end
          end
          fgc_pkg::FGC_ACK_A: if (scl_fall) begin
            bitcnt <= 4'h0;
            link <= rnw ? fgc_pkg::FGC_RD : fgc_pkg::FGC_WR;
            code_phase <= ~rnw;
            shreg <= rd_byte;
            drive_low <= rnw & ~rd_byte[7];
          end
          fgc_pkg::FGC_ACK_W: if (scl_fall) begin
            bitcnt <= 4'h0;
            link <= fgc_pkg::FGC_WR;
            drive_low <= 1'b0;
          end
          fgc_pkg::FGC_RD: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                link <= fgc_pkg::FGC_ACK_R;
                drive_low <= 1'b0;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                drive_low <= ~shreg[6];
              end
            end
          end
          fgc_pkg::FGC_ACK_R: begin
            if (scl_rise) begin
              host_nack <= sda_s2;
              ptr <= ptr + 7'h01;
            end else if (scl_fall) begin
              bitcnt <= 4'h0;
              link <= host_nack ? fgc_pkg::FGC_IDLE : fgc_pkg::FGC_RD;
              shreg <= rd_byte;
              drive_low <= ~host_nack & ~rd_byte[7];
            end
          end
          default: link <= fgc_pkg::FGC_IDLE;
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  ////////////////////////////////////////////////////////////////////////////////
  // A control byte pair never lands in the word array; it goes to the subcommand path.
  wire bw_ctl_lo   = bw_en && (bw_code == fgc_pkg::CMD_CTL);
  wire bw_ctl_hi   = bw_en && (bw_code == {fgc_pkg::CMD_CTL[6:1], 1'b1});
  wire bw_mfg      = bw_en && (bw_code[6:5] == fgc_pkg::MFG_WINDOW) && df_hit;
  wire host_reg_wr = bw_en && is_mapped(bw_code) && (bw_code[6:1] != 6'h00) &&
                     (~locked_access_state || rw_when_locked(bw_code));
  wire [15:0] temp_pick = temp_src_ext ? ext_temp_dk : die_temp_dk;
  wire soc_start = gauge_wr_en && (gauge_wr_code[6:1] == IDX_SOC) &&
                   (gauge_wr_data != regs[IDX_SOC]);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < fgc_pkg::WORD_CNT; i++) regs[i] <= fgc_pkg::RESET_WORD;
    end else begin
      if (host_reg_wr && bw_code[0]) regs[bw_code[6:1]][15:8] <= bw_data;
      if (host_reg_wr && !bw_code[0]) regs[bw_code[6:1]][7:0] <= bw_data;
      if (gauge_wr_en) regs[gauge_wr_code[6:1]] <= gauge_wr_data;
      if (temp_sample_valid) begin
        regs[IDX_TEMP] <= temp_pick;
        regs[IDX_DIE] <= die_temp_dk;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < fgc_pkg::MFG_BYTES; i++) mfg[i] <= 8'h00;
    end else if (bw_mfg) begin
      mfg[bw_code[4:0]] <= bw_data;
    end
  end

  assign temp_src_ext     = regs[IDX_OPTS][fgc_pkg::OPT_TEMP_EXT_BIT];
  assign rate_setpoint_ma = regs[IDX_RATE];

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctl_lo;
  logic        hib_req;
  logic [15:0] last_sub;
  wire  [15:0] next_sub = {bw_data, ctl_lo};
  fgc_pkg::fgc_mode_t mode, next_mode;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_lo <= 8'h00;
      ctl_sub_valid <= 1'b0;
      ctl_sub_code <= fgc_pkg::RESET_WORD;
      last_sub <= fgc_pkg::RESET_WORD;
      locked_access_state <= 1'b1;
      hib_req <= 1'b0;
    end else begin
      ctl_sub_valid <= bw_ctl_hi;
      if (bw_ctl_lo) ctl_lo <= bw_data;
      if (bw_ctl_hi) begin
        ctl_sub_code <= next_sub;
        last_sub <= next_sub;
      end
      // Locking wins over a grant arriving in the same cycle: the safer outcome.
      if (bw_ctl_hi && next_sub == fgc_pkg::SUB_LOCK) locked_access_state <= 1'b1;
      else if (unlock_grant) locked_access_state <= 1'b0;
      if (bw_ctl_hi && next_sub == fgc_pkg::SUB_SET_HIB) hib_req <= 1'b1;
      else if (bw_ctl_hi && next_sub == fgc_pkg::SUB_CLEAR_HIB) hib_req <= 1'b0;
      else if (mode == fgc_pkg::FGC_HIBERNATE && next_mode != fgc_pkg::FGC_HIBERNATE)
        hib_req <= 1'b0;
    end
  end

  always_comb begin
    ctl_resp = ctl_reply;
    if (last_sub == fgc_pkg::SUB_STATUS) begin
      ctl_resp = fgc_pkg::RESET_WORD;
      ctl_resp[fgc_pkg::ST_LOCKED_BIT] = locked_access_state;
      ctl_resp[fgc_pkg::ST_HIB_BIT] = hib_req;
      ctl_resp[fgc_pkg::ST_SLEEP_BIT] = (mode == fgc_pkg::FGC_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pack removal overrides every other mode, so a missing cell is never gauged.
  always_comb begin
    next_mode = mode;
    case (mode)
      fgc_pkg::FGC_NORMAL: if (sleep_cond) next_mode = fgc_pkg::FGC_SLEEP;
      fgc_pkg::FGC_SLEEP: begin
        if (wake_event || !sleep_cond) next_mode = fgc_pkg::FGC_NORMAL;
        else if (hib_req) next_mode = fgc_pkg::FGC_HIBERNATE;
      end
      fgc_pkg::FGC_HIBERNATE: if (wake_event) next_mode = fgc_pkg::FGC_NORMAL;
      fgc_pkg::FGC_PACK_CHECK: if (!pack_absent) next_mode = fgc_pkg::FGC_NORMAL;
      default: next_mode = fgc_pkg::FGC_NORMAL;
    endcase
    if (pack_absent) next_mode = fgc_pkg::FGC_PACK_CHECK;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) mode <= fgc_pkg::FGC_NORMAL;
    else mode <= next_mode;
  end

  assign power_mode = mode;

  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] soc_cnt;
  logic        soc_busy;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      soc_cnt <= 32'h0000_0000;
      soc_busy <= 1'b0;
    end else if (soc_start) begin
      soc_cnt <= 32'h0000_0000;
      soc_busy <= 1'b1;
    end else if (soc_busy) begin
      soc_cnt <= soc_cnt + 32'h0000_0001;
      soc_busy <= (soc_cnt != SOC_LAST);
    end
  end

  assign soc_int_out = 1'b0;
  assign soc_int_oe  = soc_busy;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_locked_ro_write;
    bw_en && locked_access_state && is_mapped(bw_code) && !rw_when_locked(bw_code);
  endsequence

  a_locked_ro_write: assert property (
    (s_locked_ro_write and (!gauge_wr_en && !temp_sample_valid)) |=>
      regs[$past(bw_code[6:1])] == $past(regs[bw_code[6:1]]))
    else $error("Locked write changed a read-only word.");
  a_temp_host_write: assert property (
    bw_en && bw_code == fgc_pkg::CMD_TEMP && !gauge_wr_en && !temp_sample_valid |=>
      regs[IDX_TEMP][7:0] == $past(bw_data))
    else $error("Temperature low byte write was lost.");
  a_ctl_sub_pulse: assert property (
    bw_ctl_hi |=> ctl_sub_valid && ctl_sub_code == {$past(bw_data), $past(ctl_lo)}
      ##1 !ctl_sub_valid)
    else $error("Subcommand not issued as a single pulse.");
  a_lock_command: assert property (
    bw_ctl_hi && next_sub == fgc_pkg::SUB_LOCK |=> locked_access_state [*2])
    else $error("Lock subcommand did not lock.");
  a_hib_entry: assert property (
    mode == fgc_pkg::FGC_SLEEP && hib_req && sleep_cond && !wake_event && !pack_absent
      |=> mode == fgc_pkg::FGC_HIBERNATE)
    else $error("Sleep with a hibernate request did not hibernate.");
  a_soc_pulse_len: assert property (
    soc_start |=> soc_int_oe [*8])
    else $error("Charge-level pulse too short.");
  a_temp_source: assert property (
    temp_sample_valid && !gauge_wr_en |=> regs[IDX_TEMP] == $past(temp_pick))
    else $error("Temperature taken from the wrong source.");
  a_addr_ack: assert property (
    link == fgc_pkg::FGC_ADDR && scl_fall && bitcnt == 4'h8 && shreg[7:1] == DEV_ADDR
      && !bus_start && !bus_stop |=> (sda_oe && link == fgc_pkg::FGC_ACK_A) [*8])
    else $error("Own address not acknowledged.");
  a_high_byte_read: assert property (
    ptr == {IDX_SOC, 1'b1} |-> rd_byte == regs[IDX_SOC][15:8])
    else $error("Odd code did not return the high byte.");
  a_mfg_write: assert property (
    bw_mfg |=> mfg[$past(bw_code[4:0])] == $past(bw_data))
    else $error("Manufacturer byte write was lost.");

endmodule

// ---- verif/fgc_host_model.sv ----
// Purpose: Host controller model on the two-wire port of the command map.
// Assumes: Open-drain lines with pull-ups; 50 mclk per bit gives 400 kHz.
// Notes:   The serial clock stands still between transfers, which saves run time.
`timescale 1ns/100ps
module fgc_host_model (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Thirty cycles low and twenty high keep the bit at 400 kHz.
  task automatic clk_bit(input logic b, output logic s);
    tick(5);
    sda_low = ~b;
    tick(25);
    scl_low = 1'b0;
    tick(20);
    s = sda_line;
    scl_low = 1'b1;
  endtask
  // A fresh transfer waits out the bus free time; a repeated one does not.
  task automatic start(input logic rep);
    if (!rep) begin
      tick(1320);
    end else begin
      tick(5);
      sda_low = 1'b0;
      tick(25);
      scl_low = 1'b0;
      tick(15);
    end
    sda_low = 1'b1;
    tick(15);
    scl_low = 1'b1;
  endtask
  task automatic stop;
    tick(5);
    sda_low = 1'b1;
    tick(25);
    scl_low = 1'b0;
    tick(15);
    sda_low = 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(last, s);
  endtask
endmodule

// ---- verif/fgc_cmd_map_tb.sv ----
// Purpose: Self-checking bench of the fuel gauge command map.
// Assumes: Host model drives the serial port; inputs change on falling mclk.
// Notes:   A 16-cycle charge pulse keeps the run short.
`timescale 1ns/100ps
module fgc_cmd_map_tb;
  localparam logic [6:0] DEV = 7'h2a;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        gauge_wr_en = 1'b0;
  logic [6:0]  gauge_wr_code = 7'h00;
  logic [15:0] gauge_wr_data = 16'h0000;
  logic        temp_sample_valid = 1'b0;
  logic        unlock_grant = 1'b0;
  logic        sleep_cond = 1'b0;
  logic        wake_event = 1'b0;
  logic        pack_absent = 1'b0;
  logic [15:0] ext_t = 16'h0b00;
  logic [15:0] die_t = 16'h0b80;
  logic [15:0] reply = 16'hc3a5;
  logic        sda_out, sda_oe, soc_out, soc_oe, locked, ext_src, sub_valid;
  logic [1:0]  power_mode;
  logic [15:0] rate_ma, sub_code, w;
  logic        scl_low, sda_low;
  wire logic   sda_line = ~(sda_low | (sda_oe & ~sda_out));
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  int          subs = 0;
  fgc_host_model host (.mclk(mclk), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));
  fgc_cmd_map #(.DEV_ADDR(DEV), .SOC_PULSE(16)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(~scl_low), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .soc_int_out(soc_out), .soc_int_oe(soc_oe),
    .gauge_wr_en(gauge_wr_en), .gauge_wr_code(gauge_wr_code), .gauge_wr_data(gauge_wr_data),
    .temp_sample_valid(temp_sample_valid), .ext_temp_dk(ext_t), .die_temp_dk(die_t),
    .ctl_reply(reply), .unlock_grant(unlock_grant), .sleep_cond(sleep_cond),
    .wake_event(wake_event), .pack_absent(pack_absent), .locked_access_state(locked),
    .power_mode(power_mode), .temp_src_ext(ext_src), .rate_setpoint_ma(rate_ma),
    .ctl_sub_valid(sub_valid), .ctl_sub_code(sub_code));
  always #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // The run budget covers about thirty-five serial transfers with bus free time.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (sub_valid === 1'b1)
      subs <= subs + 1;
    if (cycles == 110000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr_byte(input logic [6:0] code, input logic [7:0] d);
    logic a0, a1, a2;
    host.start(1'b0);
    host.send({DEV, 1'b0}, a0);
    host.send({1'b0, code}, a1);
    host.send(d, a2);
    host.stop();
    check("write ack", 16'(a0 & a1 & a2), 16'h0001);
  endtask
  // At 400 kHz each write transfer carries a single data byte.
  task automatic wr_word(input logic [6:0] code, input logic [15:0] d);
    wr_byte(code, d[7:0]);
    wr_byte(code + 7'h01, d[15:8]);
  endtask
  task automatic rd_word(input logic [6:0] code, output logic [15:0] d);
    logic a0, a1, a2;
    logic [7:0] lo, hi;
    host.start(1'b0);
    host.send({DEV, 1'b0}, a0);
    host.send({1'b0, code}, a1);
    host.start(1'b1);
    host.send({DEV, 1'b1}, a2);
    host.recv(1'b0, lo);
    host.recv(1'b1, hi);
    host.stop();
    d = {hi, lo};
    check("read ack", 16'(a0 & a1 & a2), 16'h0001);
  endtask
  task automatic rd_is(input logic [6:0] code, input logic [15:0] exp);
    rd_word(code, w);
    check("word", w, exp);
  endtask
  task automatic mode_is(input logic sc, input logic pa, input logic [1:0] m);
    sleep_cond = sc;
    pack_absent = pa;
    tick(6);
    check("power mode", 16'(power_mode), 16'(m));
  endtask
  task automatic pulse_engine(input logic [6:0] code, input logic [15:0] d);
    gauge_wr_en = 1'b1;
    gauge_wr_code = code;
    gauge_wr_data = d;
    tick(1);
    gauge_wr_en = 1'b0;
  endtask
  task automatic sample_temp;
    temp_sample_valid = 1'b1;
    tick(1);
    temp_sample_valid = 1'b0;
    tick(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic a;
    check("locked", 16'(locked), 16'h0001);
    host.start(1'b0);
    host.send({7'h2b, 1'b0}, a);
    host.stop();
    check("bad address ack", 16'(a), 16'h0000);
    rd_is(7'h06, 16'h0000);
    pulse_engine(7'h08, 16'h0e10);
    rd_is(7'h08, 16'h0e10);
    $display("reset and order test done");
  endtask
  task automatic t_locked;
    wr_word(7'h06, 16'h0bb8);
    rd_is(7'h06, 16'h0bb8);
    wr_word(7'h02, 16'hfe0c);
    check("rate", rate_ma, 16'hfe0c);
    pulse_engine(7'h2c, 16'h0032);
    tick(2);
    check("charge pin", 16'(soc_oe), 16'h0001);
    check("charge pin level", 16'(soc_out), 16'h0000);
    tick(20);
    check("charge pin end", 16'(soc_oe), 16'h0000);
    wr_byte(7'h2c, 8'h63);
    rd_is(7'h2c, 16'h0032);
    mode_is(1'b1, 1'b0, 2'b01);
    mode_is(1'b0, 1'b1, 2'b10);
    mode_is(1'b0, 1'b0, 2'b00);
    $display("locked access and mode test done");
  endtask
  task automatic t_control;
    int n;
    n = subs;
    wr_word(7'h00, 16'h0011);
    check("sub pulses", 16'(subs - n), 16'h0001);
    check("sub code", sub_code, 16'h0011);
    rd_is(7'h00, reply);
    wr_word(7'h00, 16'h0000);
    rd_is(7'h00, 16'h2040);
    mode_is(1'b1, 1'b0, 2'b11);
    wake_event = 1'b1;
    mode_is(1'b0, 1'b0, 2'b00);
    wake_event = 1'b0;
    $display("control test done");
  endtask
  task automatic t_unlock;
    sample_temp();
    rd_is(7'h06, 16'h0b80);
    unlock_grant = 1'b1;
    tick(1);
    unlock_grant = 1'b0;
    tick(2);
    check("unlocked", 16'(locked), 16'h0000);
    wr_byte(7'h08, 8'h55);
    rd_is(7'h08, 16'h0e55);
    wr_byte(7'h3a, 8'h01);
    check("ext source", 16'(ext_src), 16'h0001);
    sample_temp();
    rd_is(7'h06, 16'h0b00);
    wr_byte(7'h3e, 8'h01);
    wr_byte(7'h3f, 8'h00);
    wr_byte(7'h40, 8'h5a);
    wr_byte(7'h5f, 8'ha5);
    rd_is(7'h40, 16'h005a);
    rd_is(7'h5e, 16'ha500);
    wr_byte(7'h3e, 8'h02);
    rd_is(7'h40, 16'h0000);
    wr_word(7'h00, 16'h0020);
    check("relocked", 16'(locked), 16'h0001);
    wr_byte(7'h08, 8'haa);
    rd_is(7'h08, 16'h0e55);
    $display("unlock and flash window test done");
  endtask
  initial begin
    tick(3);
    sys_rst = 1'b0;
    tick(3);
    t_reset();
    t_locked();
    t_control();
    t_unlock();
    tally_and_finish();
  end
endmodule
